//--- hw/dhife_consts.svh
// constants for the display host interface front end
`ifndef DHIFE_CONSTS_SVH
`define DHIFE_CONSTS_SVH
`define DHIFE_STRAP_PAR18 3'h0
`define DHIFE_STRAP_PAR9 3'h1
`define DHIFE_STRAP_PAR16 3'h2
`define DHIFE_STRAP_PAR8 3'h3
`define DHIFE_STRAP_SER9 3'h5
`define DHIFE_STRAP_SER8 3'h7
`define DHIFE_CMD_TE_OFF 8'h34
`define DHIFE_CMD_TE_ON 8'h35
`define DHIFE_CMD_COL_SET 8'h2a
`define DHIFE_CMD_PAGE_SET 8'h2b
`define DHIFE_CMD_MEM_WRITE 8'h2c
`define DHIFE_CMD_MEM_READ 8'h2e
`define DHIFE_H_PIXELS 320
`define DHIFE_V_LINES 480
`define DHIFE_CLK_MHZ 200
`define DHIFE_FRAME_US 16667
`define DHIFE_TE_US 500
`define DHIFE_FRAME_CYCLES (`DHIFE_FRAME_US * `DHIFE_CLK_MHZ)
`define DHIFE_TE_CYCLES (`DHIFE_TE_US * `DHIFE_CLK_MHZ)
`define DHIFE_STRAP_WAIT 2'h3
`endif

//--- hw/dhife_front.sv
// host interface front end of a 320x480 display driver
// What this block does
// - strap pins pick parallel 18/9/16/8-bit or serial 9/8-bit link; 100, 110 refused.
// - low reset pin resets command state, window, tearing output and strap capture; frame memory and cursor keep their values.
// - transfers are taken only while chip select is low.
// - command/data select high means display data, low means command.
// - read strobe requests read data on the parallel link.
// - write strobe qualifies parallel writes, and is the serial clock on serial links.
// - serial links take input bits on the serial data pin.
// - serial links return read data on the dedicated serial output pin.
// - tearing output pulses per frame once enabled by command, low while disabled.
// - the parallel bus is 18 bits, two-way, carrying commands and data.
// - pixel interface samples video data on the host pixel clock.
// - vertical and horizontal syncs frame the incoming video.
// - video pixels are taken only while data enable is high.
// - shutdown pin blanks the display, only in pixel-interface mode.
// - colour-reduce pin selects eight-colour display, only in pixel-interface mode.
// - reduced colour keeps only each component's top bit.
// - frame memory holds 320 by 480 pixels of 18 bits.
// - host sets a column/page window and writes only inside it.
// - serial framing is 9-bit words with a lead type bit, or 8-bit words.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "dhife_consts.svh"
module dhife_front #(
  parameter int H_PIXELS = `DHIFE_H_PIXELS,
  parameter int V_LINES = `DHIFE_V_LINES,
  parameter int FRAME_CYCLES = `DHIFE_FRAME_CYCLES,
  parameter int TE_CYCLES = `DHIFE_TE_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // straps and control pins
  input wire logic reset_n_pin,
  input wire logic [2:0] link_type_strap,
  input wire logic rgb_if_select,
  input wire logic shutdown_pin,
  input wire logic colour_reduce_pin,
  // host link
  input wire dhife_pkg::dhife_host_t host_pins,
  input wire logic [17:0] parallel_bus_in,
  output logic [17:0] parallel_bus_out,
  output logic parallel_bus_oe,
  input wire logic serial_sda_in,
  output logic serial_sda_out,
  output logic serial_sda_oe,
  output logic serial_dout,
  // video input
  input wire dhife_pkg::dhife_video_t video_pins,
  // frame side
  output logic tear_sync_out,
  input wire logic [17:0] scan_addr,
  output logic [17:0] scan_pixel,
  output logic disp_shutdown,
  output logic disp_reduced,
  output logic strap_bad
);
  import dhife_pkg::*;

  localparam int SW = 34;
  localparam int MEM_WORDS = H_PIXELS * V_LINES;

  logic [SW-1:0] sync1, sync2;
  logic [7:0] sync3;
  logic [17:0] bus_s;
  logic [2:0] strap_s;
  dhife_host_t host_s, host_q;
  dhife_video_t video_s, video_q;
  logic sda_s, sd_s, cm_s, resn_s, rgb_s, pin_rst;
  logic wr_rise, wr_fall, rd_rise, rd_fall, pclk_rise, vs_fall, hs_fall, cs_on;
  dhife_link_t link;
  logic [1:0] strap_wait;
  logic strap_taken;
  logic is_serial, is_ser9;
  logic [8:0] in_sreg;
  logic [3:0] in_cnt;
  logic word_valid, word_dc;
  logic [17:0] word_data;
  dhife_cmd_st_t cmd_st;
  logic [1:0] arg_idx;
  logic [8:0] col_s, col_e, pg_s, pg_e, cur_x, cur_y;
  logic [8:0] half_data;
  logic have_half, read_half, te_on;
  logic host_we;
  logic [17:0] host_pix, host_addr, ptr_addr;
  logic [17:0] mem [MEM_WORDS];
  logic [17:0] rd_pix;
  logic ser_load;
  logic [7:0] out_sreg;
  logic [2:0] out_cnt;
  logic [8:0] dpi_x, dpi_y;
  logic dpi_line_used, dpi_we;
  logic [17:0] dpi_pix, dpi_addr;
  logic [31:0] frame_cnt;
  logic advance;

  function automatic logic [17:0] addr_of(input logic [8:0] x, input logic [8:0] y);
    logic [31:0] a;
    a = 32'(y) * 32'(H_PIXELS) + 32'(x);
    return a[17:0];
  endfunction

  function automatic logic [17:0] expand565(input logic [15:0] v);
    return {v[15:11], v[15], v[10:5], v[4:0], v[4]};
  endfunction

  function automatic logic [17:0] mask_bus(input dhife_link_t m, input logic [17:0] v);
    unique case (m)
      LINK_PAR18: return v;
      LINK_PAR16: return {2'h0, v[15:0]};
      LINK_PAR9: return {9'h000, v[8:0]};
      default: return {10'h000, v[7:0]};
    endcase
  endfunction

  // two-flop synchronisers for every pin
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      // host strobes start at their idle high level so no false edge follows reset
      sync1 <= 34'h1e00;
      sync2 <= 34'h1e00;
      sync3 <= 8'hf0;
    end else begin
      sync1 <= {parallel_bus_in, link_type_strap, host_pins, video_pins, serial_sda_in,
                shutdown_pin, colour_reduce_pin, reset_n_pin, rgb_if_select};
      sync2 <= sync1;
      sync3 <= sync2[12:5];
    end
  end

  assign bus_s = sync2[33:16];
  assign strap_s = sync2[15:13];
  assign host_s = sync2[12:9];
  assign video_s = sync2[8:5];
  assign sda_s = sync2[4];
  assign sd_s = sync2[3];
  assign cm_s = sync2[2];
  assign resn_s = sync2[1];
  assign rgb_s = sync2[0];
  assign host_q = sync3[7:4];
  assign video_q = sync3[3:0];
  assign pin_rst = ~resn_s;
  assign cs_on = ~host_s.chip_select_n;
  assign wr_rise = host_s.write_strobe_or_serial_clock & ~host_q.write_strobe_or_serial_clock;
  assign wr_fall = ~host_s.write_strobe_or_serial_clock & host_q.write_strobe_or_serial_clock;
  assign rd_rise = host_s.read_strobe_n & ~host_q.read_strobe_n;
  assign rd_fall = ~host_s.read_strobe_n & host_q.read_strobe_n;
  assign pclk_rise = video_s.pclk & ~video_q.pclk;
  assign vs_fall = ~video_s.vsync & video_q.vsync;
  assign hs_fall = ~video_s.hsync & video_q.hsync;
  assign is_serial = (link == LINK_SER9) || (link == LINK_SER8);
  assign is_ser9 = (link == LINK_SER9);

  // strap capture once the synchronisers have filled after reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      link <= LINK_BAD;
      strap_wait <= 2'h0;
      strap_taken <= 1'b0;
      strap_bad <= 1'b0;
    end else if (pin_rst) begin
      strap_wait <= 2'h0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      if (strap_wait == `DHIFE_STRAP_WAIT) begin
        strap_taken <= 1'b1;
        strap_bad <= 1'b0;
        unique case (strap_s)
          `DHIFE_STRAP_PAR18: link <= LINK_PAR18;
          `DHIFE_STRAP_PAR9: link <= LINK_PAR9;
          `DHIFE_STRAP_PAR16: link <= LINK_PAR16;
          `DHIFE_STRAP_PAR8: link <= LINK_PAR8;
          `DHIFE_STRAP_SER9: link <= LINK_SER9;
          `DHIFE_STRAP_SER8: link <= LINK_SER8;
          default: begin
            link <= LINK_BAD;
            strap_bad <= 1'b1;
          end
        endcase
      end else begin
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end

  // word extraction from parallel strobes or serial clock
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_sreg <= 9'h000;
      in_cnt <= 4'h0;
      word_valid <= 1'b0;
      word_dc <= 1'b0;
      word_data <= 18'h0_0000;
    end else if (pin_rst || link == LINK_BAD) begin
      in_cnt <= 4'h0;
      word_valid <= 1'b0;
    end else begin
      word_valid <= 1'b0;
      if (!cs_on) begin
        in_cnt <= 4'h0;
      end else if (is_serial && wr_rise) begin
        in_sreg <= {in_sreg[7:0], sda_s};
        if (in_cnt == (is_ser9 ? 4'h8 : 4'h7)) begin
          in_cnt <= 4'h0;
          word_valid <= 1'b1;
          word_dc <= is_ser9 ? in_sreg[7] : host_s.cmd_data_select;
          word_data <= {10'h000, in_sreg[6:0], sda_s};
        end else begin
          in_cnt <= in_cnt + 4'h1;
        end
      end else if (!is_serial && wr_rise && host_s.read_strobe_n) begin
        word_valid <= 1'b1;
        word_dc <= host_s.cmd_data_select;
        word_data <= mask_bus(link, bus_s);
      end
    end
  end

  assign ptr_addr = addr_of(cur_x, cur_y);
  assign rd_pix = mem[ptr_addr];
  assign ser_load = is_serial && cs_on && wr_fall && cmd_st == ARG_READ && out_cnt == 3'h0;
  assign advance = (host_we && cmd_st == ARG_WRITE) || ser_load ||
                   (cmd_st == ARG_READ && !is_serial && cs_on && rd_rise &&
                    (read_half || link == LINK_PAR18 || link == LINK_PAR16));

  // command decode, window registers and access pointer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_st <= ARG_NONE;
      arg_idx <= 2'h0;
      col_s <= 9'h000;
      col_e <= 9'(H_PIXELS - 1);
      pg_s <= 9'h000;
      pg_e <= 9'(V_LINES - 1);
      cur_x <= 9'h000;
      cur_y <= 9'h000;
      half_data <= 9'h000;
      have_half <= 1'b0;
      read_half <= 1'b0;
      te_on <= 1'b0;
      host_we <= 1'b0;
      host_pix <= 18'h0_0000;
      host_addr <= 18'h0_0000;
    end else if (pin_rst) begin
      cmd_st <= ARG_NONE;
      col_s <= 9'h000;
      col_e <= 9'(H_PIXELS - 1);
      pg_s <= 9'h000;
      pg_e <= 9'(V_LINES - 1);
      te_on <= 1'b0;
      host_we <= 1'b0;
    end else begin
      host_we <= 1'b0;
      if (advance) begin
        if (cur_x >= col_e) begin
          cur_x <= col_s;
          cur_y <= (cur_y >= pg_e) ? pg_s : cur_y + 9'h001;
        end else begin
          cur_x <= cur_x + 9'h001;
        end
      end
      if (cmd_st == ARG_READ && !is_serial && cs_on && rd_rise) begin
        read_half <= (link == LINK_PAR9 || link == LINK_PAR8) ? ~read_half : 1'b0;
      end
      if (word_valid && !word_dc) begin
        arg_idx <= 2'h0;
        have_half <= 1'b0;
        read_half <= 1'b0;
        unique case (word_data[7:0])
          `DHIFE_CMD_COL_SET: cmd_st <= ARG_COL;
          `DHIFE_CMD_PAGE_SET: cmd_st <= ARG_PAGE;
          `DHIFE_CMD_MEM_WRITE, `DHIFE_CMD_MEM_READ: begin
            cmd_st <= (word_data[7:0] == `DHIFE_CMD_MEM_WRITE) ? ARG_WRITE : ARG_READ;
            cur_x <= col_s;
            cur_y <= pg_s;
          end
          `DHIFE_CMD_TE_ON: begin
            te_on <= 1'b1;
            cmd_st <= ARG_NONE;
          end
          `DHIFE_CMD_TE_OFF: begin
            te_on <= 1'b0;
            cmd_st <= ARG_NONE;
          end
          default: cmd_st <= ARG_NONE;
        endcase
      end else if (word_valid) begin
        arg_idx <= arg_idx + 2'h1;
        if (cmd_st == ARG_COL) begin
          unique case (arg_idx)
            2'h0: col_s[8] <= word_data[0];
            2'h1: col_s[7:0] <= word_data[7:0];
            2'h2: col_e[8] <= word_data[0];
            2'h3: col_e[7:0] <= word_data[7:0];
          endcase
        end else if (cmd_st == ARG_PAGE) begin
          unique case (arg_idx)
            2'h0: pg_s[8] <= word_data[0];
            2'h1: pg_s[7:0] <= word_data[7:0];
            2'h2: pg_e[8] <= word_data[0];
            2'h3: pg_e[7:0] <= word_data[7:0];
          endcase
        end else if (cmd_st == ARG_WRITE) begin
          host_addr <= ptr_addr;
          if (link == LINK_PAR18) begin
            host_we <= 1'b1;
            host_pix <= word_data;
          end else if (link == LINK_PAR16) begin
            host_we <= 1'b1;
            host_pix <= expand565(word_data[15:0]);
          end else if (!have_half) begin
            have_half <= 1'b1;
            half_data <= word_data[8:0];
          end else begin
            have_half <= 1'b0;
            host_we <= 1'b1;
            host_pix <= (link == LINK_PAR9) ? {half_data, word_data[8:0]} :
                        expand565({half_data[7:0], word_data[7:0]});
          end
        end
      end
    end
  end

  // parallel read drive
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      parallel_bus_out <= 18'h0_0000;
      parallel_bus_oe <= 1'b0;
    end else begin
      parallel_bus_oe <= !pin_rst && !is_serial && link != LINK_BAD && cs_on &&
                         !host_s.read_strobe_n;
      if (rd_fall && cs_on && cmd_st == ARG_READ) begin
        unique case (link)
          LINK_PAR18: parallel_bus_out <= rd_pix;
          LINK_PAR16: parallel_bus_out <= {2'h0, rd_pix[17:13], rd_pix[11:6], rd_pix[5:1]};
          LINK_PAR9: parallel_bus_out <= {9'h000, read_half ? rd_pix[8:0] : rd_pix[17:9]};
          default: parallel_bus_out <= {10'h000, read_half ?
                                        {rd_pix[8:6], rd_pix[5:1]} : {rd_pix[17:13], rd_pix[11:9]}};
        endcase
      end else if (rd_fall) begin
        parallel_bus_out <= 18'h0_0000;
      end
    end
  end

  // serial read shifter, msb first on falling serial clock
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_sreg <= 8'h00;
      out_cnt <= 3'h0;
      serial_dout <= 1'b0;
      serial_sda_out <= 1'b0;
      serial_sda_oe <= 1'b0;
    end else if (pin_rst || !cs_on || cmd_st != ARG_READ) begin
      out_cnt <= 3'h0;
      serial_dout <= 1'b0;
    end else if (is_serial && wr_fall) begin
      out_cnt <= out_cnt + 3'h1;
      if (ser_load) begin
        out_sreg <= {rd_pix[16:13], rd_pix[11:9], 1'b0};
        serial_dout <= rd_pix[17];
      end else begin
        out_sreg <= {out_sreg[6:0], 1'b0};
        serial_dout <= out_sreg[7];
      end
    end
  end

  // pixel interface capture
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dpi_x <= 9'h000;
      dpi_y <= 9'h000;
      dpi_line_used <= 1'b0;
      dpi_we <= 1'b0;
      dpi_pix <= 18'h0_0000;
      dpi_addr <= 18'h0_0000;
    end else if (pin_rst || !rgb_s) begin
      dpi_x <= 9'h000;
      dpi_y <= 9'h000;
      dpi_line_used <= 1'b0;
      dpi_we <= 1'b0;
    end else begin
      dpi_we <= 1'b0;
      if (vs_fall) begin
        dpi_x <= 9'h000;
        dpi_y <= 9'h000;
        dpi_line_used <= 1'b0;
      end else if (hs_fall) begin
        dpi_x <= 9'h000;
        dpi_line_used <= 1'b0;
        if (dpi_line_used && dpi_y < 9'(V_LINES - 1)) begin
          dpi_y <= dpi_y + 9'h001;
        end
      end else if (pclk_rise && video_s.de && dpi_x < 9'(H_PIXELS)) begin
        dpi_we <= 1'b1;
        dpi_pix <= bus_s;
        dpi_addr <= addr_of(dpi_x, dpi_y);
        dpi_x <= dpi_x + 9'h001;
        dpi_line_used <= 1'b1;
      end
    end
  end

  // frame memory
  always_ff @(posedge sys_clk) begin
    if (dpi_we) begin
      mem[dpi_addr] <= dpi_pix;
    end else if (host_we) begin
      mem[host_addr] <= host_pix;
    end
  end

  // frame timer and tearing output
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_cnt <= 32'h0000_0000;
      tear_sync_out <= 1'b0;
    end else if (pin_rst) begin
      frame_cnt <= 32'h0000_0000;
      tear_sync_out <= 1'b0;
    end else begin
      frame_cnt <= (frame_cnt >= 32'(FRAME_CYCLES - 1)) ? 32'h0000_0000 : frame_cnt + 32'h0000_0001;
      tear_sync_out <= te_on && (frame_cnt < 32'(TE_CYCLES));
    end
  end

  // scan readout with shutdown and colour reduction
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      scan_pixel <= 18'h0_0000;
      disp_shutdown <= 1'b0;
      disp_reduced <= 1'b0;
    end else begin
      disp_shutdown <= rgb_s && sd_s;
      disp_reduced <= rgb_s && cm_s;
      if (rgb_s && sd_s) begin
        scan_pixel <= 18'h0_0000;
      end else if (rgb_s && cm_s) begin
        scan_pixel <= {{6{mem[scan_addr][17]}}, {6{mem[scan_addr][11]}}, {6{mem[scan_addr][5]}}};
      end else begin
        scan_pixel <= mem[scan_addr];
      end
    end
  end
endmodule

//--- hw/dhife_pkg.sv
// types for the display host interface front end
package dhife_pkg;
  typedef enum logic [2:0] {
    LINK_PAR18,
    LINK_PAR9,
    LINK_PAR16,
    LINK_PAR8,
    LINK_SER9,
    LINK_SER8,
    LINK_BAD
  } dhife_link_t;
  typedef enum logic [2:0] {
    ARG_NONE,
    ARG_COL,
    ARG_PAGE,
    ARG_WRITE,
    ARG_READ
  } dhife_cmd_st_t;
  typedef struct packed {
    logic chip_select_n;
    logic cmd_data_select;
    logic read_strobe_n;
    logic write_strobe_or_serial_clock;
  } dhife_host_t;
  typedef struct packed {
    logic pclk;
    logic vsync;
    logic hsync;
    logic de;
  } dhife_video_t;
endpackage

//--- test/dhife_front_sva.sv
// port assertions for the front end
`timescale 1ns/1ps
module dhife_front_sva #(
  parameter int FRAME_CYCLES = 200,
  parameter int TE_CYCLES = 20
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // pins
  input wire logic reset_n_pin,
  input wire logic rgb_if_select,
  input wire logic shutdown_pin,
  input wire logic colour_reduce_pin,
  input wire dhife_pkg::dhife_host_t host_pins,
  // outputs
  input wire logic parallel_bus_oe,
  input wire logic serial_sda_oe,
  input wire logic tear_sync_out,
  input wire logic disp_shutdown,
  input wire logic disp_reduced,
  input wire logic strap_bad
);
  import dhife_pkg::*;
  logic [2:0] up_cnt;
  int te_len;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      up_cnt <= 3'h0;
    end else if (!reset_n_pin) begin
      up_cnt <= 3'h0;
    end else if (up_cnt != 3'h7) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      te_len <= 0;
    end else begin
      te_len <= tear_sync_out ? te_len + 1 : 0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_shut_pin_lag: assert property (up_cnt == 3'h7 |-> disp_shutdown == $past(shutdown_pin && rgb_if_select, 3))
    else $error("shutdown output does not follow its pin");
  a_reduce_pin_lag: assert property (up_cnt == 3'h7 |-> disp_reduced == $past(colour_reduce_pin && rgb_if_select, 3))
    else $error("reduced colour output does not follow its pin");
  a_te_pulse_len: assert property (te_len <= TE_CYCLES)
    else $error("tearing pulse too long");
  a_te_gap: assert property ($fell(tear_sync_out) |=> (!tear_sync_out) [*8])
    else $error("tearing pulse repeats too soon");
  a_te_pin_reset: assert property ((!reset_n_pin) [*4] |=> !tear_sync_out)
    else $error("tearing output high during pin reset");
  a_sda_quiet: assert property (!serial_sda_oe)
    else $error("serial data pin driven");
  a_oe_cause: assert property ($rose(parallel_bus_oe) |->
      ($past(!host_pins.chip_select_n && !host_pins.read_strobe_n, 2) ||
       $past(!host_pins.chip_select_n && !host_pins.read_strobe_n, 3) ||
       $past(!host_pins.chip_select_n && !host_pins.read_strobe_n, 4)))
    else $error("bus driven without a selected read");
  a_oe_release: assert property ($rose(host_pins.chip_select_n) |-> ##[1:5] !parallel_bus_oe)
    else $error("bus still driven after deselect");
  a_bad_quiet: assert property (strap_bad |-> !parallel_bus_oe)
    else $error("bus driven with a prohibited strap");
  c_te: cover property ($rose(tear_sync_out));
  c_read: cover property ($rose(parallel_bus_oe));
  c_reduce: cover property ($rose(disp_reduced));
  c_bad: cover property ($rose(strap_bad));
endmodule
bind dhife_front dhife_front_sva #(.FRAME_CYCLES(FRAME_CYCLES), .TE_CYCLES(TE_CYCLES)) sva_u (
  .sys_clk(sys_clk), .rst_b(rst_b), .reset_n_pin(reset_n_pin), .rgb_if_select(rgb_if_select),
  .shutdown_pin(shutdown_pin), .colour_reduce_pin(colour_reduce_pin), .host_pins(host_pins),
  .parallel_bus_oe(parallel_bus_oe), .serial_sda_oe(serial_sda_oe), .tear_sync_out(tear_sync_out),
  .disp_shutdown(disp_shutdown), .disp_reduced(disp_reduced), .strap_bad(strap_bad)
);

//--- test/dhife_front_tb.sv
// self-checking bench for the front end
`timescale 1ns/1ps
module dhife_front_tb;
  import dhife_pkg::*;
  localparam int FRAME_CYC = 200;
  localparam int TE_CYC = 20;
  logic sys_clk, rst_b, reset_n_pin, rgb_if_select, shutdown_pin, colour_reduce_pin, serial_sda_in;
  logic [2:0] link_type_strap;
  dhife_host_t host_pins;
  dhife_video_t video_pins;
  logic [17:0] parallel_bus_in, parallel_bus_out, scan_addr, scan_pixel, q;
  logic parallel_bus_oe, tear_sync_out, disp_shutdown, disp_reduced, strap_bad, scan_vld, scan_d1, serial_dout;
  logic [17:0] exp_q[$];
  logic [17:0] pix[5];
  int num_errors;
  int n_compared;
  int hi;
  dhife_front #(.FRAME_CYCLES(FRAME_CYC), .TE_CYCLES(TE_CYC)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .reset_n_pin(reset_n_pin), .link_type_strap(link_type_strap),
    .rgb_if_select(rgb_if_select), .shutdown_pin(shutdown_pin), .colour_reduce_pin(colour_reduce_pin),
    .host_pins(host_pins), .parallel_bus_in(parallel_bus_in), .parallel_bus_out(parallel_bus_out),
    .parallel_bus_oe(parallel_bus_oe), .serial_sda_in(serial_sda_in), .serial_sda_out(), .serial_sda_oe(),
    .serial_dout(serial_dout), .video_pins(video_pins), .tear_sync_out(tear_sync_out), .scan_addr(scan_addr),
    .scan_pixel(scan_pixel), .disp_shutdown(disp_shutdown), .disp_reduced(disp_reduced), .strap_bad(strap_bad)
  );
  dhife_host_model host_u (
    .sys_clk(sys_clk), .host_pins(host_pins), .parallel_bus_in(parallel_bus_in),
    .parallel_bus_out(parallel_bus_out), .parallel_bus_oe(parallel_bus_oe),
    .serial_sda_in(serial_sda_in), .serial_dout(serial_dout)
  );
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [17:0] seen, input logic [17:0] want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // scan results are compared against the oldest note
  always @(posedge sys_clk) begin
    scan_d1 <= scan_vld;
    if (scan_d1) begin
      check(scan_pixel, exp_q.pop_front());
    end
  end
  task automatic expect_pix(input logic [17:0] a, input logic [17:0] want);
    scan_addr <= a;
    scan_vld <= 1'b1;
    exp_q.push_back(want);
    @(posedge sys_clk);
    scan_vld <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic set_win(input logic [8:0] c0, input logic [8:0] c1, input logic [8:0] p0, input logic [8:0] p1);
    logic [8:0] v[4];
    v = '{c0, c1, p0, p1};
    for (int k = 0; k < 4; k++) begin
      if (k % 2 == 0) host_u.wr(1'b0, 1'b0, (k == 0) ? 18'h0_002a : 18'h0_002b);
      host_u.wr(1'b0, 1'b1, {17'h0_0000, v[k][8]});
      host_u.wr(1'b0, 1'b1, {10'h000, v[k][7:0]});
    end
  endtask
  task automatic te_count(output int n);
    n = 0;
    repeat (400) begin
      @(posedge sys_clk);
      n += (tear_sync_out === 1'b1) ? 1 : 0;
    end
  endtask
  initial begin
    num_errors = 0;
    n_compared = 0;
    rst_b = 1'b0;
    reset_n_pin = 1'b1;
    link_type_strap = 3'h0;
    {rgb_if_select, shutdown_pin, colour_reduce_pin, scan_vld} = 4'h0;
    video_pins = 4'h0;
    scan_addr = 18'h0_0000;
    hi = $urandom(32'h845b);
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < 5; i++) pix[i] = 18'($urandom());
    // two windows, the second wrapping over its start
    set_win(9'h000, 9'h001, 9'h000, 9'h000);
    host_u.wr(1'b0, 1'b0, 18'h0_002c);
    for (int i = 0; i < 2; i++) host_u.wr(1'b0, 1'b1, pix[i]);
    set_win(9'h001, 9'h002, 9'h000, 9'h000);
    host_u.wr(1'b0, 1'b0, 18'h0_002c);
    for (int i = 2; i < 5; i++) host_u.wr(1'b0, 1'b1, pix[i]);
    expect_pix(18'h0_0000, pix[0]);
    expect_pix(18'h0_0001, pix[4]);
    expect_pix(18'h0_0002, pix[3]);
    // reads over a one-pixel window return the same pixel
    set_win(9'h001, 9'h001, 9'h000, 9'h000);
    host_u.wr(1'b0, 1'b0, 18'h0_002e);
    repeat (2) begin
      host_u.rd(q);
      check(q, pix[4]);
    end
    // a word with chip select high is ignored
    set_win(9'h000, 9'h000, 9'h000, 9'h000);
    host_u.wr(1'b0, 1'b0, 18'h0_002c);
    host_u.wr(1'b1, 1'b1, ~pix[0]);
    expect_pix(18'h0_0000, pix[0]);
    te_count(hi);
    check(18'(hi), 18'h0_0000);
    host_u.wr(1'b0, 1'b0, 18'h0_0035);
    te_count(hi);
    check(18'(hi), 18'(2 * TE_CYC));
    host_u.wr(1'b0, 1'b0, 18'h0_0034);
    te_count(hi);
    check(18'(hi), 18'h0_0000);
    host_u.wr(1'b0, 1'b0, 18'h0_0035);
    reset_n_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    reset_n_pin <= 1'b1;
    te_count(hi);
    check(18'(hi), 18'h0_0000);
    for (int m = 0; m < 4; m++) begin
      rgb_if_select <= m[1];
      shutdown_pin <= m[0];
      colour_reduce_pin <= ~m[0];
      repeat (8) @(posedge sys_clk);
      check({16'h0000, disp_shutdown, disp_reduced}, {16'h0000, 1'(m[1] & m[0]), 1'(m[1] & ~m[0])});
    end
    rgb_if_select <= 1'b0;
    for (int s = 0; s < 8; s++) begin
      link_type_strap <= 3'(s);
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (10) @(posedge sys_clk);
      check({17'h0_0000, strap_bad}, {17'h0_0000, 1'(s == 4 || s == 6)});
    end
    // serial 8-bit link: one pixel written as two bytes, then its high byte read back
    hi = $urandom();
    host_u.ser(1'b0, 8'h2c, q[7:0]);
    host_u.ser(1'b1, hi[15:8], q[7:0]);
    host_u.ser(1'b1, hi[7:0], q[7:0]);
    expect_pix(18'h0_0000, {hi[15:11], hi[15], hi[10:5], hi[4:0], hi[4]});
    host_u.ser(1'b0, 8'h2e, q[7:0]);
    host_u.ser(1'b1, 8'h00, q[7:0]);
    check({10'h000, q[7:0]}, {10'h000, hi[15:8]});
    wrap_up();
  end
  initial begin
    #200us;
    num_errors++;
    wrap_up();
  end
endmodule

//--- test/dhife_host_model.sv
// host side model driving the parallel and serial links
`timescale 1ns/1ps
module dhife_host_model (
  // clock
  input wire logic sys_clk,
  // host link
  output dhife_pkg::dhife_host_t host_pins,
  output wire logic [17:0] parallel_bus_in,
  input wire logic [17:0] parallel_bus_out,
  input wire logic parallel_bus_oe,
  output logic serial_sda_in,
  input wire logic serial_dout
);
  import dhife_pkg::*;
  logic host_drv;
  logic [17:0] host_d;
  // released bus shows the inverse of the last value
  assign parallel_bus_in = parallel_bus_oe ? parallel_bus_out : (host_drv ? host_d : ~host_d);
  initial begin
    host_pins = 4'hf;
    host_drv = 1'b1;
    host_d = 18'h0_0000;
    serial_sda_in = 1'b0;
  end
  task automatic phase();
    repeat (16) @(posedge sys_clk);
  endtask
  // one word written; a high chip select makes it a refused transfer
  task automatic wr(input logic cs_n, input logic dc, input logic [17:0] d);
    host_pins.chip_select_n <= cs_n;
    host_pins.cmd_data_select <= dc;
    host_pins.write_strobe_or_serial_clock <= 1'b0;
    host_drv <= 1'b1;
    host_d <= d;
    phase();
    host_pins.write_strobe_or_serial_clock <= 1'b1;
    phase();
    host_pins.chip_select_n <= 1'b1;
    host_drv <= 1'b0;
    phase();
  endtask
  // one serial byte msb first, taken on the rising serial clock; q holds what came back
  task automatic ser(input logic dc, input logic [7:0] d, output logic [7:0] q);
    host_pins.chip_select_n <= 1'b0;
    host_pins.cmd_data_select <= dc;
    for (int i = 7; i >= 0; i--) begin
      host_pins.write_strobe_or_serial_clock <= 1'b0;
      serial_sda_in <= d[i];
      phase();
      host_pins.write_strobe_or_serial_clock <= 1'b1;
      q[i] = serial_dout;
      phase();
    end
    host_pins.chip_select_n <= 1'b1;
    phase();
  endtask
  // one word read, sampled just before the strobe is released
  task automatic rd(output logic [17:0] q);
    host_pins.chip_select_n <= 1'b0;
    host_pins.cmd_data_select <= 1'b1;
    host_pins.read_strobe_n <= 1'b0;
    host_drv <= 1'b0;
    phase();
    q = parallel_bus_in;
    host_pins.read_strobe_n <= 1'b1;
    phase();
    host_pins.chip_select_n <= 1'b1;
    phase();
  endtask
endmodule
